// ===== verif/rss_status_regs_tb.sv
// Self-checking testbench for the reader status register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rss_pkg::*;
;
  // ==========================================================
  // Signals and addresses
  localparam logic [31:0] A_S1 = {22'h00_0000, RSS_ADDR_STATUS1};
  localparam logic [31:0] A_S2 = {22'h00_0000, RSS_ADDR_STATUS2};
  localparam logic [31:0] A_LV = {22'h00_0000, RSS_ADDR_LEVEL};
  localparam logic [31:0] A_WL = {22'h00_0000, RSS_ADDR_WATER};
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic err;
  rss_crc_s crc_in;
  rss_modem_s modem_in;
  logic [13:0] irq_source, irq_enable;
  logic [1:0] timer_gate_select;
  logic timer_running, timer_enabled, fifo_wr, fifo_rd, fifo_flush, temp_alarm;
  logic temp_below_limit_pin, rf_field_pin, auth_success, rx_crc_check_enable;
  logic rx_crc_bad, rx_startup, overheat_error, bus_filter_fast, cipher_active;
  logic crc_fail_flag;
  logic [2:0] modem_phase;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  rss_status_regs rss_status_regs_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .crc_in(crc_in),
    .irq_source(irq_source), .irq_enable(irq_enable), .timer_running(timer_running),
    .timer_gate_select(timer_gate_select), .timer_enabled(timer_enabled),
    .fifo_wr(fifo_wr), .fifo_rd(fifo_rd), .fifo_flush(fifo_flush), .temp_alarm(temp_alarm),
    .temp_below_limit_pin(temp_below_limit_pin), .rf_field_pin(rf_field_pin),
    .auth_success(auth_success), .rx_crc_check_enable(rx_crc_check_enable),
    .rx_crc_bad(rx_crc_bad), .rx_startup(rx_startup), .modem_in(modem_in),
    .overheat_error(overheat_error), .bus_filter_fast(bus_filter_fast),
    .cipher_active(cipher_active), .crc_fail_flag(crc_fail_flag), .modem_phase(modem_phase));

  // ==========================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      stop_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // One APB transfer: setup, access, wait for pready
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input string name, input logic [31:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rd & m, exp);
    check("pslverr", {31'h0000_0000, err}, 32'h0000_0000);
  endtask : rchk

  // ==========================================================
  // Scenarios
  task t_reset();
    rchk("status1 reset", A_S1, 32'hFFFF_FFFF, 32'h0000_0021);
    rchk("status2 reset", A_S2, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, A_S1, 32'h0000_00FF);
    rchk("status1 after write", A_S1, 32'hFFFF_FFFF, 32'h0000_0021);
    apb(1'b0, 32'h0000_003C, 32'h0000_0000);
    check("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, A_WL, 32'h0000_00FF);
    rchk("threshold", A_WL, 32'hFFFF_FFFF, 32'h0000_003F);
    $display("test reset done");
  endtask : t_reset
  task push(input int n);
    repeat (n) begin
      @(posedge pclk);
      fifo_wr <= 1'b1;
    end
    @(posedge pclk);
    fifo_wr <= 1'b0;
  endtask : push
  task t_fifo();
    apb(1'b1, A_WL, 32'h0000_0004);
    push(4);
    rchk("alerts at 4", A_S1, 32'h0000_0003, 32'h0000_0001);
    rchk("fill count", A_LV, 32'h0000_007F, 32'h0000_0004);
    @(posedge pclk) clk_en <= 1'b0;
    push(2);
    @(posedge pclk) clk_en <= 1'b1;
    rchk("fill frozen", A_LV, 32'h0000_007F, 32'h0000_0004);
    push(1);
    rchk("alerts at 5", A_S1, 32'h0000_0003, 32'h0000_0000);
    push(54);
    rchk("alerts at 59", A_S1, 32'h0000_0003, 32'h0000_0000);
    push(1);
    rchk("alerts at 60", A_S1, 32'h0000_0003, 32'h0000_0002);
    @(posedge pclk) fifo_rd <= 1'b1;
    @(posedge pclk) fifo_rd <= 1'b0;
    rchk("alerts after read", A_S1, 32'h0000_0003, 32'h0000_0000);
    @(posedge pclk) fifo_flush <= 1'b1;
    @(posedge pclk) fifo_flush <= 1'b0;
    $display("test fifo done");
  endtask : t_fifo
  task t_crc(input logic cmd, input logic zero, input logic [31:0] exp);
    @(posedge pclk) begin
      crc_in.busy <= 1'b1;
      crc_in.cmd_run <= cmd;
    end
    tick(3);
    rchk("crc busy", A_S1, 32'h0000_0060, 32'h0000_0000);
    @(posedge pclk) begin
      crc_in.finish <= 1'b1;
      crc_in.result_zero <= zero;
    end
    @(posedge pclk) begin
      crc_in.finish <= 1'b0;
      crc_in.busy <= 1'b0;
      crc_in.cmd_run <= 1'b0;
    end
    rchk("crc result", A_S1, 32'h0000_0060, exp);
    $display("test crc done");
  endtask : t_crc
  task t_irq_timer();
    logic [27:0] irq_tab [3];
    logic [3:0] tm_tab [4];
    irq_tab = '{28'h000_4000, 28'h000_4001, 28'h000_6000};
    tm_tab = '{4'h2, 4'h1, 4'hA, 4'h9};
    foreach (irq_tab[i]) begin
      @(posedge pclk) {irq_source, irq_enable} <= irq_tab[i];
      rchk("irq pending", A_S1, 32'h0000_0010, {27'h000_0000, i == 1, 4'h0});
    end
    foreach (tm_tab[i]) begin
      @(posedge pclk) {timer_gate_select, timer_running, timer_enabled} <= tm_tab[i];
      rchk("timer active", A_S1, 32'h0000_0008, {28'h000_0000, i[1] == i[0], 3'h0});
    end
    $display("test irq timer done");
  endtask : t_irq_timer
  task t_status2();
    apb(1'b1, A_S2, 32'h0000_0070);
    rchk("status2 upper", A_S2, 32'h0000_00F0, 32'h0000_0040);
    check("filter fast", {31'h0000_0000, bus_filter_fast}, 32'h0000_0001);
    @(posedge pclk) auth_success <= 1'b1;
    @(posedge pclk) auth_success <= 1'b0;
    rchk("cipher set", A_S2, 32'h0000_0008, 32'h0000_0008);
    apb(1'b1, A_S2, 32'h0000_0000);
    tick(1);
    check("cipher clr", {31'h0000_0000, cipher_active}, 32'h0000_0000);
    check("filter slow", {31'h0000_0000, bus_filter_fast}, 32'h0000_0000);
    @(posedge pclk) temp_alarm <= 1'b1;
    @(posedge pclk) temp_alarm <= 1'b0;
    apb(1'b1, A_S2, 32'h0000_0080);
    tick(1);
    check("overheat hot", {31'h0000_0000, overheat_error}, 32'h0000_0001);
    rchk("clear readback", A_S2, 32'h0000_0080, 32'h0000_0080);
    temp_below_limit_pin <= 1'b1;
    tick(6);
    apb(1'b1, A_S2, 32'h0000_0080);
    tick(1);
    check("overheat cool", {31'h0000_0000, overheat_error}, 32'h0000_0000);
    apb(1'b1, A_S2, 32'h0000_0000);
    $display("test status2 done");
  endtask : t_status2
  task t_crc_fail();
    @(posedge pclk) rx_crc_bad <= 1'b1;
    @(posedge pclk) rx_crc_bad <= 1'b0;
    tick(1);
    check("crc fail off", {31'h0000_0000, crc_fail_flag}, 32'h0000_0000);
    rx_crc_check_enable <= 1'b1;
    @(posedge pclk) rx_crc_bad <= 1'b1;
    @(posedge pclk) rx_crc_bad <= 1'b0;
    tick(1);
    check("crc fail on", {31'h0000_0000, crc_fail_flag}, 32'h0000_0001);
    @(posedge pclk) rx_startup <= 1'b1;
    @(posedge pclk) rx_startup <= 1'b0;
    tick(1);
    check("crc fail clr", {31'h0000_0000, crc_fail_flag}, 32'h0000_0000);
    $display("test crc fail done");
  endtask : t_crc_fail
  task t_modem();
    @(posedge pclk) modem_in.transceive <= 1'b1;
    tick(6);
    check("phase launch", {29'h0000_0000, modem_phase}, 32'h0000_0001);
    @(posedge pclk) modem_in.launch_transmit <= 1'b1;
    @(posedge pclk) modem_in.launch_transmit <= 1'b0;
    tick(12);
    check("phase tx wait", {29'h0000_0000, modem_phase}, 32'h0000_0002);
    rchk("status2 phase", A_S2, 32'h0000_0007, 32'h0000_0002);
    rf_field_pin <= 1'b1;
    tick(10);
    check("phase tx", {29'h0000_0000, modem_phase}, 32'h0000_0003);
    @(posedge pclk) modem_in.tx_done <= 1'b1;
    @(posedge pclk) modem_in.tx_done <= 1'b0;
    tick(1);
    check("phase rx wait", {29'h0000_0000, modem_phase}, 32'h0000_0004);
    tick(5);
    check("phase rx wait end", {29'h0000_0000, modem_phase}, 32'h0000_0004);
    tick(5);
    check("phase wait data", {29'h0000_0000, modem_phase}, 32'h0000_0005);
    @(posedge pclk) modem_in.rx_sof <= 1'b1;
    @(posedge pclk) modem_in.rx_sof <= 1'b0;
    tick(1);
    check("phase rx", {29'h0000_0000, modem_phase}, 32'h0000_0006);
    @(posedge pclk) modem_in.rx_done <= 1'b1;
    @(posedge pclk) modem_in.rx_done <= 1'b0;
    tick(1);
    check("phase relaunch", {29'h0000_0000, modem_phase}, 32'h0000_0001);
    @(posedge pclk) modem_in.transceive <= 1'b0;
    tick(2);
    check("phase idle", {29'h0000_0000, modem_phase}, 32'h0000_0000);
    $display("test modem done");
  endtask : t_modem

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0000_0000; pwdata = 32'h0000_0000; pstrb = 4'hF;
    crc_in = '0; irq_source = 14'h0000; irq_enable = 14'h0000;
    timer_running = 1'b0; timer_gate_select = 2'h0; timer_enabled = 1'b0;
    fifo_wr = 1'b0; fifo_rd = 1'b0; fifo_flush = 1'b0; temp_alarm = 1'b0;
    temp_below_limit_pin = 1'b0; rf_field_pin = 1'b0; auth_success = 1'b0;
    rx_crc_check_enable = 1'b0; rx_crc_bad = 1'b0; rx_startup = 1'b0;
    modem_in = '0;
    modem_in.tx_wait_for_field = 1'b1;
    modem_in.pre_transmit_delay = 8'h03;
    modem_in.pre_receive_delay = 8'h05;
    tick(8);
    presetn <= 1'b1;
    t_reset();
    t_fifo();
    t_crc(1'b1, 1'b1, 32'h0000_0060);
    t_crc(1'b0, 1'b0, 32'h0000_0000);
    t_irq_timer();
    t_status2();
    t_crc_fail();
    t_modem();
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// ===== verilog/rss_pkg.sv
// Constants and types shared by the reader status register bank
package rss_pkg;
  // ==========================================================
  // Register indices and byte addresses
  localparam logic [7:0] RSS_IDX_STATUS1 = 8'h07;
  localparam logic [7:0] RSS_IDX_STATUS2 = 8'h08;
  localparam logic [7:0] RSS_IDX_LEVEL = 8'h0A;
  localparam logic [7:0] RSS_IDX_WATER = 8'h0B;
  localparam logic [9:0] RSS_ADDR_STATUS1 = {RSS_IDX_STATUS1, 2'b00};
  localparam logic [9:0] RSS_ADDR_STATUS2 = {RSS_IDX_STATUS2, 2'b00};
  localparam logic [9:0] RSS_ADDR_LEVEL = {RSS_IDX_LEVEL, 2'b00};
  localparam logic [9:0] RSS_ADDR_WATER = {RSS_IDX_WATER, 2'b00};
  // ==========================================================
  // Field positions
  localparam int RSS_S1_CRC_ZERO = 6;
  localparam int RSS_S1_CRC_DONE = 5;
  localparam int RSS_S1_IRQ = 4;
  localparam int RSS_S1_TIMER = 3;
  localparam int RSS_S1_NEAR_FULL = 1;
  localparam int RSS_S1_NEAR_EMPTY = 0;
  localparam int RSS_S2_OVERHEAT_CLR = 7;
  localparam int RSS_S2_FILTER_FAST = 6;
  localparam int RSS_S2_CIPHER = 3;
  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0] RSS_RST_STATUS1 = 8'h21;
  localparam logic [7:0] RSS_RST_STATUS2 = 8'h00;
  localparam logic [5:0] RSS_RST_WATER = 6'h08;
  localparam logic [6:0] RSS_FIFO_DEPTH = 7'h40;
  // ==========================================================
  // Modem phase codes
  localparam logic [2:0] RSS_PH_IDLE = 3'h0;
  localparam logic [2:0] RSS_PH_WAIT_LAUNCH = 3'h1;
  localparam logic [2:0] RSS_PH_TX_WAIT = 3'h2;
  localparam logic [2:0] RSS_PH_TX = 3'h3;
  localparam logic [2:0] RSS_PH_RX_WAIT = 3'h4;
  localparam logic [2:0] RSS_PH_WAIT_DATA = 3'h5;
  localparam logic [2:0] RSS_PH_RX = 3'h6;
  typedef enum logic [2:0] {
    RSS_ST_IDLE, RSS_ST_WAIT_LAUNCH, RSS_ST_TX_WAIT, RSS_ST_TX,
    RSS_ST_RX_WAIT, RSS_ST_WAIT_DATA, RSS_ST_RX
  } rss_state_e;
  // ==========================================================
  // Input bundles
  typedef struct packed {
    logic busy;
    logic finish;
    logic result_zero;
    logic cmd_run;
  } rss_crc_s;
  typedef struct packed {
    logic transceive;
    logic launch_transmit;
    logic tx_wait_for_field;
    logic tx_done;
    logic rx_sof;
    logic rx_done;
    logic [7:0] pre_transmit_delay;
    logic [7:0] pre_receive_delay;
  } rss_modem_s;
endpackage : rss_pkg

// ===== verilog/rss_status_regs.sv
// Reader status register bank with APB slave and modem phase tracker
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Bit 6 reads 1 when CRC is zero
// - Bit 6 low while CRC is busy
// - Bit 5 set when CRC compute finishes
// - Bit 4 is any enabled interrupt pending
// - Bit 3 shows timer is running
// - Gated mode: bit 3 follows timer enable
// - Near full when 64 minus count <= threshold
// - Near empty when count <= threshold
// - Overheat clear works only below alarm limit
// - Filter force selects high speed filter
// - Cipher set by authentication, cleared by software
// - Phase codes idle, transmit, wait data, receive
// - Phase 001 waits for launch transmit
// - Phase 010 pre transmit wait, field option
// - Phase 100 pre receive wait, minimum delay
// - First status register resets to 21h
// - Second status register resets to 00h
// - CRC fail set on bad checked frame
// - Fill count follows FIFO writes and reads
// - Six bit warning threshold register
module rss_status_regs
  import rss_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rss_crc_s crc_in,
  input wire logic [13:0] irq_source,
  input wire logic [13:0] irq_enable,
  input wire logic timer_running,
  input wire logic [1:0] timer_gate_select,
  input wire logic timer_enabled,
  input wire logic fifo_wr,
  input wire logic fifo_rd,
  input wire logic fifo_flush,
  input wire logic temp_alarm,
  input wire logic temp_below_limit_pin,
  input wire logic rf_field_pin,
  input wire logic auth_success,
  input wire logic rx_crc_check_enable,
  input wire logic rx_crc_bad,
  input wire logic rx_startup,
  input wire rss_modem_s modem_in,
  output logic overheat_error,
  output logic bus_filter_fast,
  output logic cipher_active,
  output logic crc_fail_flag,
  output logic [2:0] modem_phase
);
  // ==========================================================
  // Pin synchronisers, three stages, change counted on agreement
  logic [1:0] pin_raw;
  logic [1:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
  assign pin_raw = {rf_field_pin, temp_below_limit_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
          pin_ff[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi]) begin
            pin_ff[gi] <= sync3_ff[gi];
          end
        end
      end
    end
  endgenerate
  wire temp_ok = pin_ff[0];
  wire field_present = pin_ff[1];

  // ==========================================================
  // APB decode
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  wire [9:0] addr_w = paddr[9:0];
  wire addr_high_zero = (paddr[31:10] == 22'h00_0000);
  wire hit_s1 = addr_high_zero && (addr_w == RSS_ADDR_STATUS1);
  wire hit_s2 = addr_high_zero && (addr_w == RSS_ADDR_STATUS2);
  wire hit_lv = addr_high_zero && (addr_w == RSS_ADDR_LEVEL);
  wire hit_wl = addr_high_zero && (addr_w == RSS_ADDR_WATER);
  wire hit_any = hit_s1 | hit_s2 | hit_lv | hit_wl;
  wire setup_ph = psel && !penable;
  wire commit = psel && penable && pready_ff;
  wire wr_s2 = commit && pwrite && hit_s2 && pstrb[0];
  wire wr_wl = commit && pwrite && hit_wl && pstrb[0];

  // ==========================================================
  // Status state
  logic crc_zero_ff, crc_done_ff, irq_ff, timer_ff;
  logic near_full_ff, near_empty_ff;
  logic [6:0] fill_ff;
  logic [5:0] water_ff;
  logic ovh_clr_ff, ovh_err_ff, filt_ff, cipher_ff, crc_fail_ff;
  rss_state_e state_ff, nxt_state;
  logic [7:0] wait_cnt_ff;
  logic [2:0] phase_ff, nxt_phase;

  // Next fill count from FIFO strobes, saturated at the ends
  wire fill_inc = fifo_wr && !fifo_rd && (fill_ff != RSS_FIFO_DEPTH);
  wire fill_dec = fifo_rd && !fifo_wr && (fill_ff != 7'h00);
  wire [6:0] nxt_fill = fifo_flush ? 7'h00 :
                        fill_inc ? fill_ff + 7'h01 :
                        fill_dec ? fill_ff - 7'h01 : fill_ff;
  wire [6:0] space_left = RSS_FIFO_DEPTH - nxt_fill;
  // Threshold as it stands after this edge, so the alerts never lag a write
  wire [5:0] nxt_water = wr_wl ? pwdata[5:0] : water_ff;
  wire nxt_near_full = (space_left <= {1'b0, nxt_water});
  wire nxt_near_empty = (nxt_fill <= {1'b0, nxt_water});
  wire nxt_irq = |(irq_source & irq_enable);
  wire gated = (timer_gate_select != 2'b00);
  wire nxt_timer = gated ? timer_enabled : timer_running;

  // Assembled register images
  wire [7:0] status1 = {1'b0, crc_zero_ff, crc_done_ff, irq_ff, timer_ff,
                        1'b0, near_full_ff, near_empty_ff};
  wire [7:0] status2 = {ovh_clr_ff, filt_ff, 2'b00, cipher_ff, phase_ff};
  wire [7:0] rd_byte = hit_s1 ? status1 :
                       hit_s2 ? status2 :
                       hit_lv ? {1'b0, fill_ff} :
                       hit_wl ? {2'b00, water_ff} : 8'h00;

  // Bus answer: pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph && !hit_any;
      prdata_ff <= (setup_ph && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // CRC flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_zero_ff <= RSS_RST_STATUS1[RSS_S1_CRC_ZERO];
      crc_done_ff <= RSS_RST_STATUS1[RSS_S1_CRC_DONE];
    end else if (clk_en) begin
      if (crc_in.finish) begin
        crc_zero_ff <= crc_in.result_zero;
      end else if (crc_in.busy) begin
        crc_zero_ff <= 1'b0;
      end
      if (crc_in.finish && crc_in.cmd_run) begin
        crc_done_ff <= 1'b1;
      end else if (crc_in.busy) begin
        crc_done_ff <= 1'b0;
      end
    end
  end

  // Live status sampling, fill count and threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= RSS_RST_STATUS1[RSS_S1_IRQ];
      timer_ff <= RSS_RST_STATUS1[RSS_S1_TIMER];
      near_full_ff <= RSS_RST_STATUS1[RSS_S1_NEAR_FULL];
      near_empty_ff <= RSS_RST_STATUS1[RSS_S1_NEAR_EMPTY];
      fill_ff <= 7'h00;
      water_ff <= RSS_RST_WATER;
    end else if (clk_en) begin
      irq_ff <= nxt_irq;
      timer_ff <= nxt_timer;
      near_full_ff <= nxt_near_full;
      near_empty_ff <= nxt_near_empty;
      fill_ff <= nxt_fill;
      if (wr_wl) begin
        water_ff <= pwdata[5:0];
      end
    end
  end

  // Second status register writable bits and hardware flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovh_clr_ff <= RSS_RST_STATUS2[RSS_S2_OVERHEAT_CLR];
      filt_ff <= RSS_RST_STATUS2[RSS_S2_FILTER_FAST];
      cipher_ff <= RSS_RST_STATUS2[RSS_S2_CIPHER];
      ovh_err_ff <= 1'b0;
      crc_fail_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_s2) begin
        ovh_clr_ff <= pwdata[RSS_S2_OVERHEAT_CLR];
        filt_ff <= pwdata[RSS_S2_FILTER_FAST];
      end
      // Sensor alarm wins over a clear in the same cycle
      if (temp_alarm) begin
        ovh_err_ff <= 1'b1;
      end else if (wr_s2 && pwdata[RSS_S2_OVERHEAT_CLR] && temp_ok) begin
        ovh_err_ff <= 1'b0;
      end
      // Authentication wins over a software clear
      if (auth_success) begin
        cipher_ff <= 1'b1;
      end else if (wr_s2 && !pwdata[RSS_S2_CIPHER]) begin
        cipher_ff <= 1'b0;
      end
      if (rx_crc_bad && rx_crc_check_enable) begin
        crc_fail_ff <= 1'b1;
      end else if (rx_startup) begin
        crc_fail_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Modem phase tracker
  wire wait_done = (wait_cnt_ff == 8'h00);
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RSS_ST_IDLE: begin
        if (modem_in.transceive) nxt_state = RSS_ST_WAIT_LAUNCH;
      end
      RSS_ST_WAIT_LAUNCH: begin
        if (modem_in.launch_transmit) nxt_state = RSS_ST_TX_WAIT;
      end
      RSS_ST_TX_WAIT: begin
        if (wait_done && (field_present || !modem_in.tx_wait_for_field)) begin
          nxt_state = RSS_ST_TX;
        end
      end
      RSS_ST_TX: begin
        if (modem_in.tx_done) nxt_state = RSS_ST_RX_WAIT;
      end
      RSS_ST_RX_WAIT: begin
        if (wait_done) nxt_state = RSS_ST_WAIT_DATA;
      end
      RSS_ST_WAIT_DATA: begin
        if (modem_in.rx_sof) nxt_state = RSS_ST_RX;
      end
      RSS_ST_RX: begin
        if (modem_in.rx_done) nxt_state = RSS_ST_WAIT_LAUNCH;
      end
    endcase
    if (!modem_in.transceive) nxt_state = RSS_ST_IDLE;
  end

  // Phase code for each state
  always_comb begin
    nxt_phase = RSS_PH_IDLE;
    unique case (nxt_state)
      RSS_ST_IDLE: nxt_phase = RSS_PH_IDLE;
      RSS_ST_WAIT_LAUNCH: nxt_phase = RSS_PH_WAIT_LAUNCH;
      RSS_ST_TX_WAIT: nxt_phase = RSS_PH_TX_WAIT;
      RSS_ST_TX: nxt_phase = RSS_PH_TX;
      RSS_ST_RX_WAIT: nxt_phase = RSS_PH_RX_WAIT;
      RSS_ST_WAIT_DATA: nxt_phase = RSS_PH_WAIT_DATA;
      RSS_ST_RX: nxt_phase = RSS_PH_RX;
    endcase
  end

  // State, phase and minimum wait counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RSS_ST_IDLE;
      phase_ff <= RSS_PH_IDLE;
      wait_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      if (nxt_state == RSS_ST_TX_WAIT && state_ff != RSS_ST_TX_WAIT) begin
        wait_cnt_ff <= modem_in.pre_transmit_delay;
      end else if (nxt_state == RSS_ST_RX_WAIT && state_ff != RSS_ST_RX_WAIT) begin
        wait_cnt_ff <= modem_in.pre_receive_delay;
      end else if (!wait_done) begin
        wait_cnt_ff <= wait_cnt_ff - 8'h01;
      end
    end
  end

  // Output drive, all from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign overheat_error = ovh_err_ff;
  assign bus_filter_fast = filt_ff;
  assign cipher_active = cipher_ff;
  assign crc_fail_flag = crc_fail_ff;
  assign modem_phase = phase_ff;

  // ==========================================================
  // Checks
  sequence s_launch_seen;
    clk_en && state_ff == RSS_ST_WAIT_LAUNCH && modem_in.launch_transmit && modem_in.transceive;
  endsequence
  sequence s_tx_wait_phase;
    modem_phase == RSS_PH_TX_WAIT;
  endsequence

  a_crc_zero_busy: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && crc_in.busy && !crc_in.finish |=> !status1[RSS_S1_CRC_ZERO])
    else $error("crc zero flag not low while busy");
  a_crc_zero_result: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && crc_in.finish |=> status1[RSS_S1_CRC_ZERO] == $past(crc_in.result_zero))
    else $error("crc zero flag does not match result");
  a_crc_done_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && crc_in.finish && crc_in.cmd_run |=> crc_done_ff)
    else $error("crc done not set after finish");
  a_irq_pending: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && |(irq_source & irq_enable) |=> irq_ff)
    else $error("pending irq not reported");
  a_near_full_calc: assert property (@(posedge pclk) disable iff (!presetn)
    near_full_ff == ((RSS_FIFO_DEPTH - fill_ff) <= {1'b0, water_ff}))
    else $error("near full flag wrong");
  a_near_empty_calc: assert property (@(posedge pclk) disable iff (!presetn)
    near_empty_ff == (fill_ff <= {1'b0, water_ff}))
    else $error("near empty flag wrong");
  a_overheat_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ovh_err_ff && !temp_ok && !temp_alarm |=> ovh_err_ff)
    else $error("overheat cleared while hot");
  a_cipher_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && auth_success |=> cipher_active)
    else $error("cipher flag not set after auth");
  a_launch_to_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_launch_seen |=> s_tx_wait_phase)
    else $error("launch did not enter pre transmit wait");
  a_rx_wait_min: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && modem_phase == RSS_PH_RX_WAIT && !wait_done && modem_in.transceive
    |=> modem_phase == RSS_PH_RX_WAIT)
    else $error("pre receive wait ended early");
  a_crc_fail_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rx_crc_bad && rx_crc_check_enable |=> crc_fail_flag)
    else $error("crc fail flag not set");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000
    && !(hit_s1 && (prdata[7] || prdata[2])) && !(hit_s2 && prdata[5:4] != 2'b00))
    else $error("reserved bit reads nonzero");
  a_fill_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && fifo_wr && !fifo_rd && !fifo_flush && fill_ff != RSS_FIFO_DEPTH
    |=> fill_ff == $past(fill_ff) + 7'h01)
    else $error("fill count did not increment");
  a_timer_free_run: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_gate_select == 2'b00 |=> timer_ff == $past(timer_running))
    else $error("timer flag does not follow running state");
  a_timer_gated: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_gate_select != 2'b00 |=> timer_ff == $past(timer_enabled))
    else $error("gated timer flag does not follow enable");
  a_filter_force: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_s2 |=> bus_filter_fast == $past(pwdata[RSS_S2_FILTER_FAST]))
    else $error("filter force bit not taken");
  a_launch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state_ff == RSS_ST_WAIT_LAUNCH && modem_in.transceive
    && !modem_in.launch_transmit |=> modem_phase == RSS_PH_WAIT_LAUNCH)
    else $error("left launch wait without launch");
  a_idle_phase: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !modem_in.transceive |=> modem_phase == RSS_PH_IDLE)
    else $error("phase not idle without transceive");
endmodule : rss_status_regs
`default_nettype wire
